/* verilog/dpio_defines.svh */
// Offsets, reset values and widths of the two parallel pin ports
`ifndef DPIO_DEFINES_SVH
`define DPIO_DEFINES_SVH

`define DPIO_P0_W           8
`define DPIO_P1_W           5
`define DPIO_SYNC_W         14

`define DPIO_IDX_W          8
`define DPIO_IDX_P0_LATCH   8'h00
`define DPIO_IDX_P1_LATCH   8'h01
`define DPIO_IDX_P0_PULL    8'h04
`define DPIO_IDX_P1_PULL    8'h05
`define DPIO_IDX_P1_DRIVE   8'h09
`define DPIO_IDX_P0_DRIVE   8'h0B
`define DPIO_IDX_P0_PINS    8'h0C
`define DPIO_IDX_P1_PINS    8'h2D

`define DPIO_P0_LATCH_RST   8'hFF
`define DPIO_P0_DRIVE_RST   8'h00
`define DPIO_P0_PULL_RST    8'h00
`define DPIO_P1_LATCH_RST   5'h1F
`define DPIO_P1_DRIVE_RST   5'h00
`define DPIO_P1_PULL_RST    5'h00

`define DPIO_RDATA_RST      32'h0000_0000
`define DPIO_TX_BIT         0
`define DPIO_RX_BIT         1

`endif

/* verilog/dpio_pkg.sv */
// Types shared by the parallel pin port design
package dpio_pkg;

	typedef enum logic [1:0]
	{
		PH_IDLE,
		PH_S1,
		PH_S2
	} dpio_phase_t;

	typedef struct packed
	{
		logic       write;
		logic [7:0] index;
	} dpio_access_t;

	typedef struct packed
	{
		logic [7:0] out;
		logic [7:0] oeN;
		logic [7:0] pullEn;
	} dpio_p0pins_t;

	typedef struct packed
	{
		logic [4:0] out;
		logic [4:0] oeN;
		logic [4:0] pullEn;
	} dpio_p1pins_t;

endpackage

/* verilog/dpio_pin_sync.sv */
// Two-stage synchroniser for the port pin inputs
`timescale 1ns/1ps
`default_nettype none
module dpio_pin_sync #(
	parameter int W = 14
)(
	// Clock and reset
	input  wire logic         ref_clk,
	input  wire logic         rst,
	// Asynchronous levels in, synchronised levels out
	input  wire logic [W-1:0] asyncIn,
	output logic      [W-1:0] syncOut
);

	logic [W-1:0] stage1_r;

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			stage1_r <= '0;
			syncOut  <= '0;
		end
		else
		begin
			stage1_r <= asyncIn;
			syncOut  <= stage1_r;
		end
	end

endmodule
`default_nettype wire

/* verilog/dpio_port_drive.sv */
// Per-pin output driver: open-drain or push-pull, pull-up enable
`timescale 1ns/1ps
`default_nettype none
module dpio_port_drive #(
	parameter int           W        = 8,
	parameter logic [W-1:0] PULL_RST = '0
)(
	// Clock and reset
	input  wire logic         ref_clk,
	input  wire logic         rst,
	// Next register contents
	input  wire logic [W-1:0] latchNxt,
	input  wire logic [W-1:0] pushPullNxt,
	input  wire logic [W-1:0] pullNxt,
	input  wire logic [W-1:0] releaseNxt,
	// Pin side
	output logic      [W-1:0] pinOut,
	output logic      [W-1:0] pinOeN,
	output logic      [W-1:0] pullEn
);

	genvar i;
	generate
		for (i = 0; i < W; i++)
		begin : gBit
			always_ff @(posedge ref_clk)
			begin
				if (rst)
				begin
					pinOut[i] <= 1'b0;
					pinOeN[i] <= 1'b1;
					pullEn[i] <= PULL_RST[i];
				end
				else
				begin
					pullEn[i] <= pullNxt[i];
					if (releaseNxt[i])
					begin
						pinOut[i] <= 1'b0;
						pinOeN[i] <= 1'b1;
					end
					else if (pushPullNxt[i])
					begin
						pinOut[i] <= latchNxt[i];
						pinOeN[i] <= 1'b0;
					end
					else
					begin
						pinOut[i] <= 1'b0;
						pinOeN[i] <= latchNxt[i];
					end
				end
			end
		end
	endgenerate

endmodule
`default_nettype wire

/* verilog/dpio_ports_top.sv */
// Two parallel pin ports behind an AHB-Lite register slave
`timescale 1ns/1ps
`default_nettype none
`include "dpio_defines.svh"
module dpio_ports_top
	import dpio_pkg::*;
(
	// Clock and reset
	input  wire logic         ref_clk,
	input  wire logic         rst,
	// AHB-Lite slave
	input  wire logic         hsel,
	input  wire logic [31:0]  haddr,
	input  wire logic [1:0]   htrans,
	input  wire logic         hwrite,
	input  wire logic [2:0]   hsize,
	input  wire logic [31:0]  hwdata,
	input  wire logic         hready,
	output logic              hreadyout,
	output logic      [31:0]  hrdata,
	output logic              hresp,
	// First port pins
	input  wire logic [7:0]   p0PinIn,
	output wire dpio_p0pins_t p0Pins,
	// Second port pins
	input  wire logic [4:0]   p1PinIn,
	output wire dpio_p1pins_t p1Pins,
	// Serial programming mode
	input  wire logic         serialProgMode,
	input  wire logic         firstSerialTransmit,
	output logic              firstSerialReceive
);

	// Index of a word address, all ones when outside the map
	function automatic logic [7:0] addrIndex(input logic [31:0] a);
		if (a[31:10] != 22'h00_0000 || a[1:0] != 2'h0)
			return 8'hFF;
		return a[9:2];
	endfunction

	// Index matches a register
	function automatic logic isReg(input logic [7:0] idx, input logic [7:0] code);
		return idx == code;
	endfunction

	dpio_phase_t  phase_r;
	dpio_access_t acc_r;
	logic         hreadyout_r;
	logic [31:0]  hrdata_r;
	logic         hresp_r;
	logic         firstSerialReceive_r;

	logic [7:0]   p0Latch_r;
	logic [7:0]   p0Drive_r;
	logic [7:0]   p0Pull_r;
	logic [4:0]   p1Latch_r;
	logic [4:0]   p1Drive_r;
	logic [4:0]   p1Pull_r;
	logic [7:0]   p0Latch_nxt;
	logic [7:0]   p0Drive_nxt;
	logic [7:0]   p0Pull_nxt;
	logic [4:0]   p1Latch_nxt;
	logic [4:0]   p1Drive_nxt;
	logic [4:0]   p1Pull_nxt;

	logic [7:0]   p0EffLatch;
	logic [7:0]   p0EffDrive;
	logic [7:0]   p0Release;

	logic [13:0]  pinSync;
	logic [7:0]   p0PinSync;
	logic [4:0]   p1PinSync;
	logic         serialProgSync;

	logic         accept;
	logic         wrEn;
	logic         rdEn;
	logic [31:0]  rdMux;

	logic [7:0]   p0Out;
	logic [7:0]   p0OeN;
	logic [7:0]   p0PullEn;
	logic [4:0]   p1Out;
	logic [4:0]   p1OeN;
	logic [4:0]   p1PullEn;

	// Pin input synchroniser
	dpio_pin_sync #(
		.W       (`DPIO_SYNC_W)
	) uSync (
		.ref_clk (ref_clk),
		.rst     (rst),
		.asyncIn ({serialProgMode, p1PinIn, p0PinIn}),
		.syncOut (pinSync)
	);

	assign p0PinSync      = pinSync[7:0];
	assign p1PinSync      = pinSync[12:8];
	assign serialProgSync = pinSync[13];

	// Bus phase sequencing
	assign accept = hsel && htrans[1] && hready && (phase_r != PH_S1);
	assign wrEn   = (phase_r == PH_S1) && acc_r.write;
	assign rdEn   = (phase_r == PH_S1) && !acc_r.write;

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			phase_r <= PH_IDLE;
		else
		begin
			unique case (phase_r)
				PH_IDLE: phase_r <= accept ? PH_S1 : PH_IDLE;
				PH_S1:   phase_r <= PH_S2;
				PH_S2:   phase_r <= accept ? PH_S1 : PH_IDLE;
				default: phase_r <= PH_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			acc_r <= '0;
		else if (accept)
		begin
			acc_r.write <= hwrite;
			acc_r.index <= addrIndex(haddr);
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			hreadyout_r <= 1'b1;
			hresp_r     <= 1'b0;
		end
		else
		begin
			hreadyout_r <= !accept;
			hresp_r     <= 1'b0;
		end
	end

	// Register next values, written at the end of S1
	always_comb
	begin
		p0Latch_nxt = p0Latch_r;
		p0Drive_nxt = p0Drive_r;
		p0Pull_nxt  = p0Pull_r;
		p1Latch_nxt = p1Latch_r;
		p1Drive_nxt = p1Drive_r;
		p1Pull_nxt  = p1Pull_r;
		if (wrEn)
		begin
			if (isReg(acc_r.index, `DPIO_IDX_P0_LATCH))
				p0Latch_nxt = hwdata[7:0];
			if (isReg(acc_r.index, `DPIO_IDX_P0_DRIVE))
				p0Drive_nxt = hwdata[7:0];
			if (isReg(acc_r.index, `DPIO_IDX_P0_PULL))
				p0Pull_nxt = hwdata[7:0];
			if (isReg(acc_r.index, `DPIO_IDX_P1_LATCH))
				p1Latch_nxt = hwdata[4:0];
			if (isReg(acc_r.index, `DPIO_IDX_P1_DRIVE))
				p1Drive_nxt = hwdata[4:0];
			if (isReg(acc_r.index, `DPIO_IDX_P1_PULL))
				p1Pull_nxt = hwdata[4:0];
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			p0Latch_r <= `DPIO_P0_LATCH_RST;
			p0Drive_r <= `DPIO_P0_DRIVE_RST;
			p0Pull_r  <= `DPIO_P0_PULL_RST;
		end
		else
		begin
			p0Latch_r <= p0Latch_nxt;
			p0Drive_r <= p0Drive_nxt;
			p0Pull_r  <= p0Pull_nxt;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			p1Latch_r <= `DPIO_P1_LATCH_RST;
			p1Drive_r <= `DPIO_P1_DRIVE_RST;
			p1Pull_r  <= `DPIO_P1_PULL_RST;
		end
		else
		begin
			p1Latch_r <= p1Latch_nxt;
			p1Drive_r <= p1Drive_nxt;
			p1Pull_r  <= p1Pull_nxt;
		end
	end

	// Serial programming override of the first port
	always_comb
	begin
		p0EffLatch = p0Latch_nxt;
		p0EffDrive = p0Drive_nxt;
		p0Release  = 8'h00;
		if (serialProgSync)
		begin
			p0EffLatch[`DPIO_TX_BIT] = firstSerialTransmit;
			p0EffDrive[`DPIO_TX_BIT] = 1'b1;
			p0Release[`DPIO_RX_BIT]  = 1'b1;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			firstSerialReceive_r <= 1'b1;
		else
			firstSerialReceive_r <= serialProgSync ? p0PinSync[`DPIO_RX_BIT] : 1'b1;
	end

	// Pin drivers, updated on the same edge as the latches
	dpio_port_drive #(
		.W           (`DPIO_P0_W),
		.PULL_RST    (`DPIO_P0_PULL_RST)
	) uDrive0 (
		.ref_clk     (ref_clk),
		.rst         (rst),
		.latchNxt    (p0EffLatch),
		.pushPullNxt (p0EffDrive),
		.pullNxt     (p0Pull_nxt),
		.releaseNxt  (p0Release),
		.pinOut      (p0Out),
		.pinOeN      (p0OeN),
		.pullEn      (p0PullEn)
	);

	dpio_port_drive #(
		.W           (`DPIO_P1_W),
		.PULL_RST    (`DPIO_P1_PULL_RST)
	) uDrive1 (
		.ref_clk     (ref_clk),
		.rst         (rst),
		.latchNxt    (p1Latch_nxt),
		.pushPullNxt (p1Drive_nxt),
		.pullNxt     (p1Pull_nxt),
		.releaseNxt  (5'h00),
		.pinOut      (p1Out),
		.pinOeN      (p1OeN),
		.pullEn      (p1PullEn)
	);

	assign p0Pins = '{out: p0Out, oeN: p0OeN, pullEn: p0PullEn};
	assign p1Pins = '{out: p1Out, oeN: p1OeN, pullEn: p1PullEn};

	// Read mux; pins are sampled during S1
	always_comb
	begin
		rdMux = `DPIO_RDATA_RST;
		unique case (acc_r.index)
			`DPIO_IDX_P0_LATCH: rdMux[7:0] = p0Latch_r;
			`DPIO_IDX_P0_DRIVE: rdMux[7:0] = p0Drive_r;
			`DPIO_IDX_P0_PULL:  rdMux[7:0] = p0Pull_r;
			`DPIO_IDX_P0_PINS:  rdMux[7:0] = p0PinSync;
			`DPIO_IDX_P1_LATCH: rdMux[4:0] = p1Latch_r;
			`DPIO_IDX_P1_DRIVE: rdMux[4:0] = p1Drive_r;
			`DPIO_IDX_P1_PULL:  rdMux[4:0] = p1Pull_r;
			`DPIO_IDX_P1_PINS:  rdMux[4:0] = p1PinSync;
			default:            rdMux = `DPIO_RDATA_RST;
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			hrdata_r <= `DPIO_RDATA_RST;
		else if (rdEn)
			hrdata_r <= rdMux;
	end

	assign hreadyout          = hreadyout_r;
	assign hrdata             = hrdata_r;
	assign hresp              = hresp_r;
	assign firstSerialReceive = firstSerialReceive_r;

	// Checks
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	chk_latch_hold: assert property (
		!(wrEn && isReg(acc_r.index, `DPIO_IDX_P0_LATCH)) |=> $stable(p0Latch_r))
		else $error("first port latch changed without a write");

	chk_pin_sample: assert property (
		rdEn && isReg(acc_r.index, `DPIO_IDX_P0_PINS)
		|=> hrdata == {24'h00_0000, $past(p0PinSync)})
		else $error("pin read did not return S1 pin levels");

	chk_write_s2: assert property (
		wrEn && isReg(acc_r.index, `DPIO_IDX_P1_LATCH)
		|=> phase_r == PH_S2 && p1Latch_r == $past(hwdata[4:0]))
		else $error("second port latch not updated in S2");

	chk_reset_first: assert property (
		$past(rst) |-> p0Latch_r == 8'hFF && p0Drive_r == 8'h00 && p0Pins.oeN == 8'hFF)
		else $error("first port reset values wrong");

	chk_reset_second: assert property (
		$past(rst) |-> p1Latch_r == 5'h1F && p1Drive_r == 5'h00 && p1Pins.oeN == 5'h1F)
		else $error("second port reset values wrong");

	chk_drive_mode: assert property (
		!$past(rst) |-> p1Pins.oeN == (p1Latch_r & ~p1Drive_r)
		&& p1Pins.out == (p1Latch_r & p1Drive_r))
		else $error("second port driver does not follow latch and mode");

	chk_first_drive: assert property (
		!serialProgSync && !$past(serialProgSync) && !$past(rst)
		|-> p0Pins.oeN == (p0Latch_r & ~p0Drive_r) && p0Pins.out == (p0Latch_r & p0Drive_r))
		else $error("first port driver does not follow latch and mode");

	chk_pullup_follow: assert property (
		!$past(rst) |-> p0Pins.pullEn == p0Pull_r && p1Pins.pullEn == p1Pull_r)
		else $error("pull-up enables differ from control registers");

	chk_latch_read: assert property (
		rdEn && isReg(acc_r.index, `DPIO_IDX_P0_LATCH) |=> hrdata[7:0] == $past(p0Latch_r))
		else $error("latch read returned wrong value");

	chk_ready_wait: assert property (
		accept |=> !hreadyout ##1 hreadyout)
		else $error("data phase is not exactly one wait state");

	chk_prog_tx: assert property (
		serialProgSync |=> !p0Pins.oeN[0] && p0Pins.out[0] == $past(firstSerialTransmit)
		&& p0Pins.oeN[1])
		else $error("serial programming pins not overridden");

endmodule
`default_nettype wire

/* sim/dpio_pin_model.sv */
// Board side of the two ports: resolves each pin wire
`timescale 1ns/1ps
`default_nettype none
module dpio_pin_model
	import dpio_pkg::*;
(
	// Clock
	input  wire logic         ref_clk,
	// Device pin drivers
	input  wire dpio_p0pins_t p0Pins,
	input  wire dpio_p1pins_t p1Pins,
	// Board sources on released pins
	input  wire logic [12:0]  extVal,
	input  wire logic [12:0]  extEn,
	// Resolved levels
	output logic      [7:0]   p0PinIn,
	output logic      [4:0]   p1PinIn
);
	logic [12:0] oeN;
	logic [12:0] out;
	logic [12:0] pull;
	logic [12:0] lvl;
	logic [12:0] noise = '0;
	assign oeN  = {p1Pins.oeN, p0Pins.oeN};
	assign out  = {p1Pins.out, p0Pins.out};
	assign pull = {p1Pins.pullEn, p0Pins.pullEn};
	// Floating pins wander so a stale level never passes
	always @(posedge ref_clk)
		noise <= ~noise;
	// Driver first, then pull-up, then the board source held steady
	assign lvl = (~oeN & out) | (oeN & (pull | (extEn & extVal) | (~extEn & noise)));
	assign p0PinIn = lvl[7:0];
	assign p1PinIn = lvl[12:8];
endmodule
`default_nettype wire

/* sim/tb_dual_parallel_io_ports.sv */
// Self-checking bench for the two parallel pin ports
`timescale 1ns/1ps
`default_nettype none
`include "dpio_defines.svh"
module tb_dual_parallel_io_ports;
	import dpio_pkg::*;
	logic         ref_clk = 0;
	logic         rst = 1;
	logic         hsel = 0;
	logic         hwrite = 0;
	logic [1:0]   htrans = 0;
	logic [31:0]  haddr = 0;
	logic [31:0]  hwdata = 0;
	logic         serialProgMode = 0;
	logic         firstSerialTransmit = 0;
	logic         rdPend = 0;
	logic [31:0]  x = 24;
	logic [12:0]  extVal = 0;
	logic [12:0]  extEn = '1;
	logic [12:0]  lat;
	logic [12:0]  drv;
	logic [12:0]  pul;
	wire logic    hreadyout;
	wire logic    hresp;
	wire logic    firstSerialReceive;
	wire logic [31:0] hrdata;
	wire logic [7:0]  p0PinIn;
	wire logic [4:0]  p1PinIn;
	wire dpio_p0pins_t p0Pins;
	wire dpio_p1pins_t p1Pins;
	logic [31:0]  expQ[$];
	int           n_errors = 0;
	int           total_checks = 0;

	dpio_ports_top dut (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.p0PinIn(p0PinIn), .p0Pins(p0Pins), .p1PinIn(p1PinIn), .p1Pins(p1Pins),
		.serialProgMode(serialProgMode), .firstSerialTransmit(firstSerialTransmit),
		.firstSerialReceive(firstSerialReceive));
	dpio_pin_model board (.ref_clk(ref_clk), .p0Pins(p0Pins), .p1Pins(p1Pins),
		.extVal(extVal), .extEn(extEn), .p0PinIn(p0PinIn), .p1PinIn(p1PinIn));

	always #12.5 ref_clk = ~ref_clk;

	function automatic logic [31:0] xs(input logic [31:0] v);
		v = v ^ (v << 13);
		v = v ^ (v >> 17);
		v = v ^ (v << 5);
		return v;
	endfunction

	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic cmpReg(input logic [31:0] got, input logic [31:0] e);
		total_checks++;
		if (got !== e)
		begin
			n_errors++;
			$display("MISMATCH %0t read data got %h exp %h", $time, got, e);
		end
	endtask

	task automatic cmpPin(input logic [12:0] got, input logic [12:0] e, input string what);
		total_checks++;
		if (got !== e)
		begin
			n_errors++;
			$display("MISMATCH %0t %s got %h exp %h", $time, what, got, e);
		end
	endtask

	// One single AHB-Lite transfer, waits on hready in both phases
	task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
		haddr  <= {22'h00_0000, idx, 2'b00};
		hwrite <= wr;
		hsel   <= 1'b1;
		htrans <= 2'b10;
		@(posedge ref_clk);
		while (hreadyout !== 1'b1)
			@(posedge ref_clk);
		htrans <= 2'b00;
		hsel   <= 1'b0;
		hwdata <= wd;
		rdPend <= !wr;
		@(posedge ref_clk);
		while (hreadyout !== 1'b1)
			@(posedge ref_clk);
		rdPend <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] idx, input logic [31:0] d);
		bus(1'b1, idx, d);
	endtask

	task automatic rd(input logic [7:0] idx, input logic [31:0] e);
		expQ.push_back(e);
		bus(1'b0, idx, 32'h0000_0000);
	endtask

	// Read results taken at the completing edge
	always @(posedge ref_clk)
		if (rdPend && hreadyout === 1'b1)
		begin
			cmpReg(hrdata, expQ.pop_front());
			cmpPin(13'(hresp), 13'h0000, "response");
		end

	task automatic cfg();
		wr(`DPIO_IDX_P0_LATCH, 32'(lat[7:0]));
		wr(`DPIO_IDX_P1_LATCH, 32'(lat[12:8]));
		wr(`DPIO_IDX_P0_PULL, 32'(pul[7:0]));
		wr(`DPIO_IDX_P1_PULL, 32'(pul[12:8]));
		wr(`DPIO_IDX_P0_DRIVE, 32'(drv[7:0]));
		wr(`DPIO_IDX_P1_DRIVE, 32'(drv[12:8]));
	endtask

	task automatic check();
		logic [12:0] oe;
		logic [12:0] pin;
		repeat (3) @(posedge ref_clk);
		oe = ~drv & lat;
		pin = (~oe & drv & lat) | (oe & (pul | (extEn & extVal)));
		cmpPin({p1Pins.oeN, p0Pins.oeN}, oe, "enables");
		cmpPin(~oe & {p1Pins.out, p0Pins.out}, drv & lat, "outputs");
		cmpPin({p1Pins.pullEn, p0Pins.pullEn}, pul, "pull-ups");
		cmpPin(13'(firstSerialReceive), 13'h0001, "receive idle");
		rd(`DPIO_IDX_P0_LATCH, 32'(lat[7:0]));
		rd(`DPIO_IDX_P1_LATCH, 32'(lat[12:8]));
		rd(`DPIO_IDX_P0_DRIVE, 32'(drv[7:0]));
		rd(`DPIO_IDX_P1_DRIVE, 32'(drv[12:8]));
		rd(`DPIO_IDX_P0_PULL, 32'(pul[7:0]));
		rd(`DPIO_IDX_P1_PULL, 32'(pul[12:8]));
		rd(`DPIO_IDX_P0_PINS, 32'(pin[7:0]));
		rd(`DPIO_IDX_P1_PINS, 32'(pin[12:8]));
	endtask

	initial
	begin
		#(25 * 20000);
		n_errors++;
		results();
	end

	initial
	begin
		repeat (8) @(posedge ref_clk);
		rst <= 1'b0;
		lat = '1;
		drv = '0;
		pul = '0;
		check();
		$display("test reset values done");
		for (int i = 0; i < 6; i++)
		begin
			x = xs(x);
			lat = x[12:0];
			x = xs(x);
			drv = (i == 0) ? '1 : (i == 1) ? '0 : x[12:0];
			x = xs(x);
			pul = (i == 1) ? '1 : x[12:0];
			x = xs(x);
			extVal <= x[12:0];
			extEn  <= (i == 1) ? 13'h0000 : 13'h1FFF;
			cfg();
			check();
		end
		$display("test drive modes done");
		x = xs(x);
		wr(8'h02, x);
		rd(8'h02, 32'h0000_0000);
		wr(`DPIO_IDX_P0_PINS, x);
		check();
		$display("test unmapped and read-only done");
		wr(`DPIO_IDX_P0_LATCH, 32'h0000_00FF);
		wr(`DPIO_IDX_P1_LATCH, 32'h0000_001F);
		serialProgMode <= 1'b1;
		for (int i = 0; i < 2; i++)
		begin
			x = xs(x);
			firstSerialTransmit <= x[0];
			extVal <= x[13:1];
			repeat (6) @(posedge ref_clk);
			cmpPin({11'h000, p0Pins.oeN[1:0]}, 13'h0002, "serial enables");
			cmpPin({11'h000, firstSerialReceive, p0Pins.out[0]},
				{11'h000, pul[1] | x[2], x[0]}, "serial data");
		end
		serialProgMode <= 1'b0;
		$display("test serial mode done");
		repeat (4) @(posedge ref_clk);
		rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		lat = '1;
		drv = '0;
		pul = '0;
		check();
		$display("test second reset done");
		repeat (4) @(posedge ref_clk);
		results();
	end
endmodule
`default_nettype wire
